// ### common/uart_shadow_pkg.sv
// constants of the uart shadow-alias and software-reset register group
// assumes an 8-bit byte address on the plain register port
package uart_shadow_pkg;

    // ==================================================================
    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ==================================================================
    // register byte offsets
    localparam logic [7:0] OFF_SOFTWARE_RESET         = 8'h88;
    localparam logic [7:0] OFF_REQUEST_TO_SEND_ALIAS  = 8'h8C;
    localparam logic [7:0] OFF_BREAK_CONTROL_ALIAS    = 8'h90;
    localparam logic [7:0] OFF_DMA_MODE_ALIAS         = 8'h94;
    localparam logic [7:0] OFF_FIFO_ENABLE_ALIAS      = 8'h98;
    localparam logic [7:0] OFF_RECEIVE_TRIGGER_ALIAS  = 8'h9C;
    localparam logic [7:0] OFF_TX_EMPTY_TRIGGER_ALIAS = 8'hA0;

    // ==================================================================
    // software reset fields
    localparam int SWR_WHOLE_PORT = 0;
    localparam int SWR_RX_FLUSH   = 1;
    localparam int SWR_TX_FLUSH   = 2;

    // ==================================================================
    // primary control register field positions
    localparam int QCR_FIFO_ENABLE = 0;
    localparam int QCR_RX_FLUSH    = 1;
    localparam int QCR_TX_FLUSH    = 2;
    localparam int QCR_DMA_MODE    = 3;
    localparam int QCR_TX_TRIG_LO  = 4;
    localparam int QCR_RX_TRIG_LO  = 6;
    localparam int MODEM_RTS       = 1;
    localparam int LINE_BREAK      = 6;

    // ==================================================================
    // values after reset
    localparam logic       RST_RTS         = 1'b0;
    localparam logic       RST_BREAK       = 1'b0;
    localparam logic       RST_DMA_MODE    = 1'b0;
    localparam logic       RST_FIFO_ENABLE = 1'b0;
    localparam logic [1:0] RST_RX_TRIGGER  = 2'h0;
    localparam logic [1:0] RST_TX_TRIGGER  = 2'h0;

    // ==================================================================
    // reset release synchroniser depth, in clock cycles
    localparam int RELEASE_CYCLES = 2;

endpackage

// ### rtl/reset_release_sync.sv
// reset stretcher: asserts at once on a request, releases on the clock
// assumes the request comes from a flip-flop on the same clock
`timescale 1ns/10ps
`default_nettype none

module reset_release_sync
    import uart_shadow_pkg::*;
(
    // clocking
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic ce,
    // request and stretched reset
    input  wire logic req,
    output logic      rst_out
);

    logic [RELEASE_CYCLES-1:0] stage;

    // asynchronous assertion, clocked release
    always_ff @(posedge clk or posedge req) begin
        if (req) begin
            stage <= '1;
        end else if (srst) begin
            stage <= '0;
        end else if (ce) begin
            stage <= {stage[RELEASE_CYCLES-2:0], 1'b0};
        end
    end

    assign rst_out = stage[RELEASE_CYCLES-1];

endmodule // reset_release_sync

`default_nettype wire

// ### rtl/uart_shadow_reset_regs.sv
// uart shadow-alias registers and software reset register
// assumes primary control registers live elsewhere and write through ports
// Summary of operation
// - bit 2 write flushes transmit queue
// - bit 1 write flushes receive queue
// - no FIFOs: flush writes ignored
// - bit 0 resets port, clocked release
// - reset bits write-only, upper bits zero
// - 0x8C bit 0 aliases request-to-send
// - 0x90 bit 0 aliases break control
// - 0x94 bit 0 aliases DMA mode
// - 0x98 bit 0 aliases FIFO enable
// - 0x9C bits 1:0 alias receive trigger
// - queue aliases need FIFOs and shadow
// - 0xA0 needs FIFOs, threshold, shadow options
// - 0xA0 bits mirror transmit-empty trigger
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module uart_shadow_reset_regs
    import uart_shadow_pkg::*;
#(
    parameter bit FIFO_PRESENT        = 1'b1,
    parameter bit SHADOW_PRESENT      = 1'b1,
    parameter bit TX_THRESHOLD_OPTION = 1'b1
) (
    // clocking
    input  wire logic                              clk,
    input  wire logic                              srst,
    input  wire logic                              ce,
    // register port
    input  wire logic [uart_shadow_pkg::ADDR_W-1:0] addr,
    input  wire logic [uart_shadow_pkg::DATA_W-1:0] wdata,
    input  wire logic                              wr,
    input  wire logic                              rd,
    output logic      [uart_shadow_pkg::DATA_W-1:0] rdata,
    // primary control register writes
    input  wire logic                              qcr_wr,
    input  wire logic [7:0]                        qcr_wdata,
    input  wire logic                              modem_wr,
    input  wire logic [7:0]                        modem_wdata,
    input  wire logic                              line_wr,
    input  wire logic [7:0]                        line_wdata,
    // shared control state
    output logic                                   rts,
    output logic                                   break_ctl,
    output logic                                   dma_mode,
    output logic                                   fifo_enable,
    output logic      [1:0]                        rx_trigger,
    output logic      [1:0]                        tx_empty_trigger,
    // reset actions
    output logic                                   tx_queue_flush,
    output logic                                   rx_queue_flush,
    output logic                                   whole_port_reset
);

    import uart_shadow_pkg::*;

    // ==================================================================
    // decode
    localparam bit QUEUE_ALIAS = FIFO_PRESENT && SHADOW_PRESENT;
    localparam bit TXT_ALIAS   = QUEUE_ALIAS && TX_THRESHOLD_OPTION;

    logic bus_wr;
    logic bus_rd;
    logic wr_swr;
    logic wr_rts;
    logic wr_brk;
    logic wr_dma;
    logic wr_fen;
    logic wr_rxt;
    logic wr_txt;
    logic port_req;
    logic state_rst;
    logic next_tx_flush;
    logic next_rx_flush;

    assign bus_wr = wr && ce;
    assign bus_rd = rd && ce;
    assign wr_swr = bus_wr && SHADOW_PRESENT && (addr == OFF_SOFTWARE_RESET);
    assign wr_rts = bus_wr && SHADOW_PRESENT && (addr == OFF_REQUEST_TO_SEND_ALIAS);
    assign wr_brk = bus_wr && SHADOW_PRESENT && (addr == OFF_BREAK_CONTROL_ALIAS);
    assign wr_dma = bus_wr && QUEUE_ALIAS && (addr == OFF_DMA_MODE_ALIAS);
    assign wr_fen = bus_wr && QUEUE_ALIAS && (addr == OFF_FIFO_ENABLE_ALIAS);
    assign wr_rxt = bus_wr && QUEUE_ALIAS && (addr == OFF_RECEIVE_TRIGGER_ALIAS);
    assign wr_txt = bus_wr && TXT_ALIAS && (addr == OFF_TX_EMPTY_TRIGGER_ALIAS);

    assign state_rst = srst || whole_port_reset;

    // ==================================================================
    // shared storage, bus alias write wins over a primary write
    always_ff @(posedge clk) begin
        if (state_rst) begin
            rts <= RST_RTS;
        end else if (wr_rts) begin
            rts <= wdata[0];
        end else if (modem_wr && ce) begin
            rts <= modem_wdata[MODEM_RTS];
        end
    end

    always_ff @(posedge clk) begin
        if (state_rst) begin
            break_ctl <= RST_BREAK;
        end else if (wr_brk) begin
            break_ctl <= wdata[0];
        end else if (line_wr && ce) begin
            break_ctl <= line_wdata[LINE_BREAK];
        end
    end

    always_ff @(posedge clk) begin
        if (state_rst) begin
            dma_mode    <= RST_DMA_MODE;
            fifo_enable <= RST_FIFO_ENABLE;
            rx_trigger  <= RST_RX_TRIGGER;
        end else begin
            if (wr_dma) begin
                dma_mode <= wdata[0];
            end else if (qcr_wr && ce) begin
                dma_mode <= qcr_wdata[QCR_DMA_MODE];
            end
            if (wr_fen) begin
                fifo_enable <= wdata[0];
            end else if (qcr_wr && ce) begin
                fifo_enable <= qcr_wdata[QCR_FIFO_ENABLE];
            end
            if (wr_rxt) begin
                rx_trigger <= wdata[1:0];
            end else if (qcr_wr && ce) begin
                rx_trigger <= qcr_wdata[QCR_RX_TRIG_LO+:2];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (state_rst) begin
            tx_empty_trigger <= RST_TX_TRIGGER;
        end else if (wr_txt) begin
            tx_empty_trigger <= wdata[1:0];
        end else if (qcr_wr && ce && TX_THRESHOLD_OPTION) begin
            tx_empty_trigger <= qcr_wdata[QCR_TX_TRIG_LO+:2];
        end
    end

    // ==================================================================
    // reset actions: one-cycle flush pulses from either path, stretched port reset from the reset word only
    always_comb begin
        next_tx_flush = 1'b0;
        next_rx_flush = 1'b0;
        if (FIFO_PRESENT) begin
            next_tx_flush = (wr_swr && wdata[SWR_TX_FLUSH])
                         || (qcr_wr && ce && qcr_wdata[QCR_TX_FLUSH]);
            next_rx_flush = (wr_swr && wdata[SWR_RX_FLUSH])
                         || (qcr_wr && ce && qcr_wdata[QCR_RX_FLUSH]);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            tx_queue_flush <= 1'b0;
            rx_queue_flush <= 1'b0;
        end else if (ce) begin
            tx_queue_flush <= next_tx_flush;
            rx_queue_flush <= next_rx_flush;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            port_req <= 1'b0;
        end else if (ce) begin
            port_req <= wr_swr && wdata[SWR_WHOLE_PORT];
        end
    end

    reset_release_sync u_release (
        .clk     (clk),
        .srst    (srst),
        .ce      (ce),
        .req     (port_req),
        .rst_out (whole_port_reset)
    );

    // ==================================================================
    // read data, valid only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= '0;
        end else if (ce) begin
            rdata <= '0;
            if (bus_rd) begin
                unique case (addr)
                    OFF_REQUEST_TO_SEND_ALIAS: begin
                        rdata[0] <= SHADOW_PRESENT && rts;
                    end
                    OFF_BREAK_CONTROL_ALIAS: begin
                        rdata[0] <= SHADOW_PRESENT && break_ctl;
                    end
                    OFF_DMA_MODE_ALIAS: begin
                        rdata[0] <= QUEUE_ALIAS && dma_mode;
                    end
                    OFF_FIFO_ENABLE_ALIAS: begin
                        rdata[0] <= QUEUE_ALIAS && fifo_enable;
                    end
                    OFF_RECEIVE_TRIGGER_ALIAS: begin
                        rdata[1:0] <= QUEUE_ALIAS ? rx_trigger : 2'h0;
                    end
                    OFF_TX_EMPTY_TRIGGER_ALIAS: begin
                        rdata[1:0] <= TXT_ALIAS ? tx_empty_trigger : 2'h0;
                    end
                    default: begin
                        rdata <= '0;
                    end
                endcase
            end
        end
    end

    // ==================================================================
    // checks
    sequence s_swr_write(int bitpos);
        wr && ce && SHADOW_PRESENT && (addr == OFF_SOFTWARE_RESET) && wdata[bitpos];
    endsequence

    sequence s_port_idle;
        !(wr && ce && (addr == OFF_SOFTWARE_RESET) && wdata[SWR_WHOLE_PORT]);
    endsequence

    sequence s_port_reset_held;
        whole_port_reset [*3];
    endsequence

    AST_TX_FLUSH: assert property (@(posedge clk) disable iff (srst)
        s_swr_write(SWR_TX_FLUSH) |=> (tx_queue_flush == FIFO_PRESENT))
        else $error("transmit flush did not follow reset write");

    AST_RX_FLUSH: assert property (@(posedge clk) disable iff (srst)
        s_swr_write(SWR_RX_FLUSH) |=> (rx_queue_flush == FIFO_PRESENT))
        else $error("receive flush did not follow reset write");

    AST_NO_FIFO_FLUSH: assert property (@(posedge clk) disable iff (srst)
        !FIFO_PRESENT |-> !tx_queue_flush && !rx_queue_flush)
        else $error("flush seen without FIFOs");

    AST_PORT_RESET: assert property (@(posedge clk) disable iff (srst || !ce)
        s_swr_write(SWR_WHOLE_PORT) |=> s_port_reset_held)
        else $error("port reset not held after reset write");

    AST_PORT_RELEASE: assert property (@(posedge clk) disable iff (srst || !ce)
        s_swr_write(SWR_WHOLE_PORT) ##1 s_port_idle [*3] |=> !whole_port_reset)
        else $error("port reset not released on the clock");

    AST_RESET_READ_ZERO: assert property (@(posedge clk) disable iff (srst)
        rd && ce && (addr == OFF_SOFTWARE_RESET) |=> rdata == '0)
        else $error("software reset register read not zero");

    AST_RTS_WRITE: assert property (@(posedge clk) disable iff (state_rst)
        wr && ce && SHADOW_PRESENT && (addr == OFF_REQUEST_TO_SEND_ALIAS)
            |=> rts == $past(wdata[0]) || whole_port_reset)
        else $error("request-to-send alias write lost");

    AST_BREAK_READ: assert property (@(posedge clk) disable iff (srst)
        rd && ce && (addr == OFF_BREAK_CONTROL_ALIAS)
            |=> rdata == {31'h0, SHADOW_PRESENT && $past(break_ctl)})
        else $error("break alias read mismatch");

    AST_TXT_READ: assert property (@(posedge clk) disable iff (srst)
        rd && ce && (addr == OFF_TX_EMPTY_TRIGGER_ALIAS)
            |=> rdata[31:2] == 30'h0 && (TXT_ALIAS || rdata[1:0] == 2'h0))
        else $error("transmit-empty trigger read mismatch");

    AST_SHARED_FEN: assert property (@(posedge clk) disable iff (state_rst)
        qcr_wr && ce && !wr_fen |=> fifo_enable == $past(qcr_wdata[QCR_FIFO_ENABLE]) || whole_port_reset)
        else $error("primary write not seen through fifo enable alias");

    AST_FLUSH_PULSE: assert property (@(posedge clk) disable iff (srst || !ce)
        tx_queue_flush && !(wr && (addr == OFF_SOFTWARE_RESET) && wdata[SWR_TX_FLUSH])
            && !(qcr_wr && qcr_wdata[QCR_TX_FLUSH]) |=> !tx_queue_flush)
        else $error("transmit flush held beyond one cycle");

    AST_RX_FLUSH_PULSE: assert property (@(posedge clk) disable iff (srst || !ce)
        rx_queue_flush && !(wr && (addr == OFF_SOFTWARE_RESET) && wdata[SWR_RX_FLUSH])
            && !(qcr_wr && qcr_wdata[QCR_RX_FLUSH]) |=> !rx_queue_flush)
        else $error("receive flush held beyond one cycle");

    AST_RXT_READ: assert property (@(posedge clk) disable iff (srst)
        rd && ce && (addr == OFF_RECEIVE_TRIGGER_ALIAS)
            |=> rdata == {30'h0, QUEUE_ALIAS ? $past(rx_trigger) : 2'h0})
        else $error("receive trigger alias read mismatch");

    AST_TXT_WRITE: assert property (@(posedge clk) disable iff (state_rst)
        wr && ce && (addr == OFF_TX_EMPTY_TRIGGER_ALIAS)
            |=> tx_empty_trigger == $past(wdata[1:0]) || !TXT_ALIAS || whole_port_reset)
        else $error("transmit-empty trigger alias write lost");

    AST_CE_FREEZE: assert property (@(posedge clk) disable iff (srst)
        !ce && !state_rst |=> $stable(rts) && $stable(break_ctl) && $stable(fifo_enable) && $stable(rx_trigger))
        else $error("shared control moved while clock enable low");

endmodule // uart_shadow_reset_regs

`default_nettype wire

// ### sim/testbench.sv
// self-checking bench for the uart shadow-alias and software reset registers
// assumes the package and design files are compiled first
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import uart_shadow_pkg::*;

    // ==================================================================
    // signals
    logic                clk;
    logic                srst;
    logic                ce;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
    logic                wr;
    logic                rd;
    logic [DATA_W-1:0]   rdata;
    logic                qcr_wr;
    logic [7:0]          qcr_wdata;
    logic                modem_wr;
    logic [7:0]          modem_wdata;
    logic                line_wr;
    logic [7:0]          line_wdata;
    logic                rts;
    logic                break_ctl;
    logic                dma_mode;
    logic                fifo_enable;
    logic [1:0]          rx_trigger;
    logic [1:0]          tx_empty_trigger;
    logic                tx_queue_flush;
    logic                rx_queue_flush;
    logic                whole_port_reset;
    logic [DATA_W-1:0]   nf_rdata;
    logic                nf_tx_queue_flush;
    logic                nf_rx_queue_flush;
    int                  err_count;
    int                  checks;
    logic [7:0]          offs [6];
    logic [1:0]          masks [6];

    uart_shadow_reset_regs u_uart_shadow_reset_regs (
        .clk(clk), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .qcr_wr(qcr_wr), .qcr_wdata(qcr_wdata), .modem_wr(modem_wr), .modem_wdata(modem_wdata),
        .line_wr(line_wr), .line_wdata(line_wdata), .rts(rts), .break_ctl(break_ctl), .dma_mode(dma_mode),
        .fifo_enable(fifo_enable), .rx_trigger(rx_trigger), .tx_empty_trigger(tx_empty_trigger),
        .tx_queue_flush(tx_queue_flush), .rx_queue_flush(rx_queue_flush),
        .whole_port_reset(whole_port_reset)
    );

    // same bus, built without FIFOs: queue aliases and flushes stay dead
    uart_shadow_reset_regs #(
        .FIFO_PRESENT(1'b0)
    ) u_uart_shadow_reset_regs_nofifo (
        .clk(clk), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(nf_rdata),
        .qcr_wr(qcr_wr), .qcr_wdata(qcr_wdata), .modem_wr(modem_wr), .modem_wdata(modem_wdata),
        .line_wr(line_wr), .line_wdata(line_wdata), .rts(), .break_ctl(), .dma_mode(),
        .fifo_enable(), .rx_trigger(), .tx_empty_trigger(),
        .tx_queue_flush(nf_tx_queue_flush), .rx_queue_flush(nf_rx_queue_flush), .whole_port_reset()
    );

    // ==================================================================
    // clock and watchdog
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        #100000;
        err_count++;
        summarize();
    end

    // ==================================================================
    // helpers
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_test(input string name);
        $display("test %s done, %0d mismatches so far", name, err_count);
    endtask

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // one-cycle bus write; returns just after the taking edge
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
        #1;
    endtask

    // one-cycle bus read; data compared in the following cycle only
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        check(rdata, exp);
    endtask

    // primary register write pulse: 0 queue, 1 modem, 2 line control
    task automatic prim(input int sel, input logic [7:0] d);
        @(posedge clk);
        qcr_wr      <= (sel == 0);
        modem_wr    <= (sel == 1);
        line_wr     <= (sel == 2);
        qcr_wdata   <= d;
        modem_wdata <= d;
        line_wdata  <= d;
        @(posedge clk);
        qcr_wr   <= 1'b0;
        modem_wr <= 1'b0;
        line_wr  <= 1'b0;
        #1;
    endtask

    function automatic logic [1:0] ctl(input int i);
        case (i)
            0: return {1'b0, rts};
            1: return {1'b0, break_ctl};
            2: return {1'b0, dma_mode};
            3: return {1'b0, fifo_enable};
            4: return rx_trigger;
            default: return tx_empty_trigger;
        endcase
    endfunction

    // ==================================================================
    // main sequence
    initial begin
        srst = 1'b1; ce = 1'b1; addr = 8'h00; wdata = 32'h0; wr = 1'b0; rd = 1'b0;
        qcr_wr = 1'b0; qcr_wdata = 8'h00; modem_wr = 1'b0; modem_wdata = 8'h00;
        line_wr = 1'b0; line_wdata = 8'h00; err_count = 0; checks = 0;
        offs  = '{OFF_REQUEST_TO_SEND_ALIAS, OFF_BREAK_CONTROL_ALIAS, OFF_DMA_MODE_ALIAS,
                  OFF_FIFO_ENABLE_ALIAS, OFF_RECEIVE_TRIGGER_ALIAS, OFF_TX_EMPTY_TRIGGER_ALIAS};
        masks = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h3, 2'h3};
        repeat (6) @(posedge clk);
        srst <= 1'b0;

        // reset values of every alias and of the software reset word
        for (int i = 0; i < 6; i++) begin
            rd_reg(offs[i], 32'h0);
            check({30'h0, ctl(i)}, 32'h0);
        end
        rd_reg(OFF_SOFTWARE_RESET, 32'h0);
        end_test("reset_values");

        // every code through each alias, reserved bits set on write
        for (int i = 0; i < 6; i++) begin
            for (int v = 0; v < 4; v++) begin
                wr_reg(offs[i], 32'hFFFFFFFC | 32'(v));
                check({30'h0, ctl(i)}, {30'h0, 2'(v) & masks[i]});
                rd_reg(offs[i], {30'h0, 2'(v) & masks[i]});
                check(nf_rdata, (i < 2) ? {30'h0, 2'(v) & masks[i]} : 32'h0);
            end
        end
        end_test("alias_codes");

        // primary writes seen through the aliases
        prim(1, 8'hFD);
        rd_reg(OFF_REQUEST_TO_SEND_ALIAS, 32'h0);
        prim(2, 8'hBF);
        rd_reg(OFF_BREAK_CONTROL_ALIAS, 32'h0);
        prim(0, 8'h60);
        rd_reg(OFF_DMA_MODE_ALIAS, 32'h0);
        rd_reg(OFF_FIFO_ENABLE_ALIAS, 32'h0);
        rd_reg(OFF_RECEIVE_TRIGGER_ALIAS, 32'h1);
        rd_reg(OFF_TX_EMPTY_TRIGGER_ALIAS, 32'h2);
        @(posedge clk); #1;
        check(rdata, 32'h0);
        prim(1, 8'h02);
        rd_reg(OFF_REQUEST_TO_SEND_ALIAS, 32'h1);
        prim(2, 8'h40);
        rd_reg(OFF_BREAK_CONTROL_ALIAS, 32'h1);
        end_test("primary_path");

        // unmapped places read zero
        wr_reg(8'h00, 32'hFFFFFFFF);
        rd_reg(8'h00, 32'h0);
        rd_reg(8'hA4, 32'h0);
        end_test("unmapped");

        // flush pulses from the software reset word and the primary path
        wr_reg(OFF_SOFTWARE_RESET, 32'hFFFFFFF4);
        check({31'h0, tx_queue_flush}, 32'h1);
        check({31'h0, rx_queue_flush}, 32'h0);
        check({31'h0, whole_port_reset}, 32'h0);
        check({31'h0, nf_tx_queue_flush}, 32'h0);
        @(posedge clk); #1;
        check({31'h0, tx_queue_flush}, 32'h0);
        wr_reg(OFF_SOFTWARE_RESET, 32'h2);
        check({31'h0, rx_queue_flush}, 32'h1);
        check({31'h0, tx_queue_flush}, 32'h0);
        check({31'h0, nf_rx_queue_flush}, 32'h0);
        @(posedge clk); #1;
        check({31'h0, rx_queue_flush}, 32'h0);
        prim(0, 8'h04);
        check({31'h0, tx_queue_flush}, 32'h1);
        prim(0, 8'h02);
        check({31'h0, rx_queue_flush}, 32'h1);
        rd_reg(OFF_SOFTWARE_RESET, 32'h0);
        end_test("queue_flush");

        // whole port reset clears shared controls and then releases
        wr_reg(OFF_REQUEST_TO_SEND_ALIAS, 32'h1);
        wr_reg(OFF_RECEIVE_TRIGGER_ALIAS, 32'h2);
        wr_reg(OFF_SOFTWARE_RESET, 32'h1);
        check({31'h0, whole_port_reset}, 32'h1);
        @(posedge clk); #1;
        check({31'h0, whole_port_reset}, 32'h1);
        repeat (2) @(posedge clk);
        #1;
        check({31'h0, whole_port_reset}, 32'h0);
        check({31'h0, rts}, 32'h0);
        check({30'h0, rx_trigger}, 32'h0);
        rd_reg(OFF_RECEIVE_TRIGGER_ALIAS, 32'h0);
        end_test("port_reset");

        // writes are ignored while the clock enable is low
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(OFF_RECEIVE_TRIGGER_ALIAS, 32'h2);
        check({30'h0, rx_trigger}, 32'h0);
        @(posedge clk);
        ce <= 1'b1;
        rd_reg(OFF_RECEIVE_TRIGGER_ALIAS, 32'h0);
        end_test("clock_enable");

        summarize();
    end

endmodule // testbench

`default_nettype wire
